// ---- hw/usb_alloc_consts.svh ----
// Register offsets, field positions, reset values and sizes of the FIFO allocation block
`ifndef USB_ALLOC_CONSTS_SVH
`define USB_ALLOC_CONSTS_SVH
`define OFF_ROLE_STATUS     8'h60
`define OFF_TX_SIZING       8'h62
`define OFF_RX_SIZING       8'h63
`define OFF_TX_START        8'h64
`define OFF_RX_START        8'h66
`define OFF_EP_INDEX        8'h0e
`define OFF_IRQ_STATUS      8'h40
`define OFF_IRQ_MASK        8'h41
`define ROLE_STATUS_RESET   8'h80
`define ROLE_STATUS_FS_BIT  6
`define ROLE_STATUS_LS_BIT  5
`define ROLE_STATUS_HOST_BIT 2
`define SIZING_DPB_BIT      4
`define SIZING_MASK         8'h1f
`define START_MASK          16'h01ff
`define SIZING_RESET        8'h00
`define START_RESET         16'h0000
`define MAX_SIZE_CODE       4'h8
`define BASE_PACKET_BYTES   13'h0008
`define NUM_EP              4
`define EP_INDEX_MASK       8'h03
`endif

// ---- hw/usb_alloc_pkg.sv ----
// Types shared by the FIFO allocation block
package usb_alloc_pkg;
    typedef struct packed {
        logic [12:0] start_byte;
        logic [12:0] size_bytes;
        logic        double_buffer_enable;
    } fifo_alloc_t;
    typedef struct packed {
        logic session_active;
        logic host_role;
        logic full_speed_attached;
        logic low_speed_attached;
    } role_in_t;
endpackage

// ---- hw/usb_fifo_alloc_and_role_status.sv ----
// Role and attach status plus per-endpoint FIFO sizing and start registers
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "usb_alloc_consts.svh"
module usb_fifo_alloc_and_role_status
    import usb_alloc_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rdata_o,
    // Controller state, same clock
    input  wire role_in_t    role_i,
    // Allocation of the selected endpoint
    output logic      [1:0]  sel_ep_o,
    output fifo_alloc_t      tx_alloc_o,
    output fifo_alloc_t      rx_alloc_o,
    // Interrupt
    output logic             irq_o
);
    logic [7:0]  tx_size   [`NUM_EP];
    logic [7:0]  rx_size   [`NUM_EP];
    logic [15:0] tx_start  [`NUM_EP];
    logic [15:0] rx_start  [`NUM_EP];
    logic [7:0]  next_tx_size  [`NUM_EP];
    logic [7:0]  next_rx_size  [`NUM_EP];
    logic [15:0] next_tx_start [`NUM_EP];
    logic [15:0] next_rx_start [`NUM_EP];
    logic [1:0]  ep_index;
    logic [1:0]  next_ep_index;
    logic [7:0]  role_status;
    logic [7:0]  next_role_status;
    logic [1:0]  irq_status;
    logic [1:0]  next_irq_status;
    logic [1:0]  irq_mask;
    logic [1:0]  next_irq_mask;
    logic [15:0] next_rdata;
    logic        prev_host;
    logic        prev_attach;
    logic        next_prev_host;
    logic        next_prev_attach;
    fifo_alloc_t next_tx_alloc;
    fifo_alloc_t next_rx_alloc;

    // Reserved codes give zero space rather than a wrapped size
    function automatic fifo_alloc_t alloc_of(input logic [7:0] sz, input logic [15:0] st);
        fifo_alloc_t a;
        a.double_buffer_enable = sz[`SIZING_DPB_BIT];
        a.size_bytes = (sz[3:0] > `MAX_SIZE_CODE) ? 13'h0000 :
                       13'(`BASE_PACKET_BYTES << sz[3:0]);
        if (a.double_buffer_enable && a.size_bytes != 13'h1000) begin
            a.size_bytes = 13'(a.size_bytes << 1);
        end
        a.start_byte = {st[8:0], 4'h0} >> 1;
        return a;
    endfunction

    // One decode feeds both strobes so reads and writes share one map
    function automatic logic [7:0] reg_hit(input logic [7:0] a);
        logic [7:0] hit;
        hit = 8'h00;
        case (a)
            `OFF_ROLE_STATUS: hit[0] = 1'b1;
            `OFF_EP_INDEX:    hit[1] = 1'b1;
            `OFF_TX_SIZING:   hit[2] = 1'b1;
            `OFF_RX_SIZING:   hit[3] = 1'b1;
            `OFF_TX_START:    hit[4] = 1'b1;
            `OFF_RX_START:    hit[5] = 1'b1;
            `OFF_IRQ_STATUS:  hit[6] = 1'b1;
            `OFF_IRQ_MASK:    hit[7] = 1'b1;
            default:          hit = 8'h00;
        endcase
        return hit;
    endfunction

    logic [7:0]  wr_hit;
    logic [7:0]  rd_hit;
    logic        host_event;
    logic        attach_event;
    logic        next_irq;

    // A write to the status offset sets only wr_hit[0], which no register uses; unmapped offsets decode to nothing
    assign wr_hit = wr_i ? reg_hit(addr_i) : 8'h00;
    assign rd_hit = rd_i ? reg_hit(addr_i) : 8'h00;

    // Endpoint index
    always_comb begin
        next_ep_index = ep_index;
        if (wr_hit[1]) begin
            next_ep_index = wdata_i[1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ep_index <= 2'h0;
        end else begin
            ep_index <= next_ep_index;
        end
    end

    // Sizing storage; only the indexed endpoint takes a write
    for (genvar e = 0; e < `NUM_EP; e++) begin : g_size
        always_comb begin
            next_tx_size[e] = tx_size[e];
            next_rx_size[e] = rx_size[e];
            if (ep_index == 2'(e)) begin
                if (wr_hit[2]) begin
                    next_tx_size[e] = wdata_i[7:0] & `SIZING_MASK;
                end
                if (wr_hit[3]) begin
                    next_rx_size[e] = wdata_i[7:0] & `SIZING_MASK;
                end
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                tx_size[e] <= `SIZING_RESET;
                rx_size[e] <= `SIZING_RESET;
            end else begin
                tx_size[e] <= next_tx_size[e];
                rx_size[e] <= next_rx_size[e];
            end
        end
    end

    // Start address storage; only the indexed endpoint takes a write
    for (genvar e = 0; e < `NUM_EP; e++) begin : g_start
        always_comb begin
            next_tx_start[e] = tx_start[e];
            next_rx_start[e] = rx_start[e];
            if (ep_index == 2'(e)) begin
                if (wr_hit[4]) begin
                    next_tx_start[e] = wdata_i & `START_MASK;
                end
                if (wr_hit[5]) begin
                    next_rx_start[e] = wdata_i & `START_MASK;
                end
            end
        end

        always_ff @(posedge ref_clk_i) begin
            if (reset_i) begin
                tx_start[e] <= `START_RESET;
                rx_start[e] <= `START_RESET;
            end else begin
                tx_start[e] <= next_tx_start[e];
                rx_start[e] <= next_rx_start[e];
            end
        end
    end

    // Status mirrors live controller state every cycle, one cycle late
    always_comb begin
        next_role_status = 8'h00;
        next_role_status[`ROLE_STATUS_FS_BIT]   = role_i.full_speed_attached;
        next_role_status[`ROLE_STATUS_LS_BIT]   = role_i.low_speed_attached;
        next_role_status[`ROLE_STATUS_HOST_BIT] = role_i.host_role;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            role_status <= `ROLE_STATUS_RESET;
        end else begin
            role_status <= next_role_status;
        end
    end

    // Change detectors reset to the idle controller, so no false event follows reset
    always_comb begin
        next_prev_host   = role_i.host_role;
        next_prev_attach = role_i.full_speed_attached | role_i.low_speed_attached;
        host_event       = role_i.host_role != prev_host;
        attach_event     = next_prev_attach != prev_attach;
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            prev_host   <= 1'b0;
            prev_attach <= 1'b0;
        end else begin
            prev_host   <= next_prev_host;
            prev_attach <= next_prev_attach;
        end
    end

    // Interrupt mask
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_hit[7]) begin
            next_irq_mask = wdata_i[1:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_mask <= 2'h0;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // Sticky status; events set after the clear so a same-cycle event survives
    always_comb begin
        next_irq_status = irq_status;
        if (wr_hit[6]) begin
            next_irq_status = irq_status & ~wdata_i[1:0];
        end
        if (host_event) begin
            next_irq_status[0] = 1'b1;
        end
        if (attach_event) begin
            next_irq_status[1] = 1'b1;
        end
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end

    // Read data stands one cycle only; an idle or unmapped read returns zero
    always_comb begin
        next_rdata = 16'h0000;
        if (rd_hit[0]) begin
            next_rdata = {8'h00, role_status};
        end
        if (rd_hit[1]) begin
            next_rdata = {14'h0000, ep_index};
        end
        if (rd_hit[2]) begin
            next_rdata = {8'h00, tx_size[ep_index]};
        end
        if (rd_hit[3]) begin
            next_rdata = {8'h00, rx_size[ep_index]};
        end
        if (rd_hit[4]) begin
            next_rdata = tx_start[ep_index];
        end
        if (rd_hit[5]) begin
            next_rdata = rx_start[ep_index];
        end
        if (rd_hit[6]) begin
            next_rdata = {14'h0000, irq_status};
        end
        if (rd_hit[7]) begin
            next_rdata = {14'h0000, irq_mask};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // Allocation follows the next index and contents so it lands with the write
    always_comb begin
        next_tx_alloc = alloc_of(next_tx_size[next_ep_index], next_tx_start[next_ep_index]);
        next_rx_alloc = alloc_of(next_rx_size[next_ep_index], next_rx_start[next_ep_index]);
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            tx_alloc_o <= '0;
            rx_alloc_o <= '0;
        end else begin
            tx_alloc_o <= next_tx_alloc;
            rx_alloc_o <= next_rx_alloc;
        end
    end

    // Index and interrupt outputs
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sel_ep_o <= 2'h0;
            irq_o    <= 1'b0;
        end else begin
            sel_ep_o <= next_ep_index;
            irq_o    <= next_irq;
        end
    end
endmodule // usb_fifo_alloc_and_role_status

// ---- test/usb_alloc_properties.sv ----
// Checker for the role status and FIFO allocation block
`timescale 1ns/1ps
module usb_alloc_props
    import usb_alloc_pkg::*;
(
    input wire logic        ref_clk_i, reset_i, wr_i, rd_i, irq_o,
    input wire logic [7:0]  addr_i,
    input wire logic [15:0] wdata_i, rdata_o,
    input wire logic [1:0]  sel_ep_o,
    input wire role_in_t    role_i,
    input wire fifo_alloc_t tx_alloc_o, rx_alloc_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // Reads right after reset still see the reset value, so they are left out
    sequence s_st; $past(rd_i && addr_i == 8'h60) && !$past(reset_i, 2); endsequence
    property p_att; s_st |-> rdata_o[6:5] == $past(role_i[1:0], 2); endproperty
    a_att: assert property (p_att) else $error("attach bits wrong");
    property p_host; s_st |-> rdata_o[2] == $past(role_i.host_role, 2); endproperty
    a_host: assert property (p_host) else $error("host bit wrong");
    property p_ro; s_st |-> {rdata_o[15:7], rdata_o[4:3], rdata_o[1:0]} == 13'h0; endproperty
    a_ro: assert property (p_ro) else $error("status spare bits set");
    property p_sel; wr_i && addr_i == 8'h0e |=> sel_ep_o == $past(wdata_i[1:0]); endproperty
    a_sel: assert property (p_sel) else $error("index wrong");
    property p_dbl; wr_i && addr_i == 8'h62 |=> tx_alloc_o.double_buffer_enable == $past(wdata_i[4]);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double flag wrong");
    property p_size; wr_i && addr_i == 8'h62 && wdata_i[3:0] < 4'h9 |=>
        tx_alloc_o.size_bytes == (13'h8 << $past(wdata_i[3:0])) << $past(wdata_i[4]); endproperty
    a_size: assert property (p_size) else $error("size wrong");
    property p_start; wr_i && addr_i == 8'h66 |=> rx_alloc_o.start_byte == {$past(wdata_i[8:0]), 3'h0};
    endproperty
    a_start: assert property (p_start) else $error("start wrong");
    property p_rdz; !rd_i |=> rdata_o == 16'h0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not idle");
endmodule // usb_alloc_props
bind usb_fifo_alloc_and_role_status usb_alloc_props u_props (.*);

// ---- test/usb_role_partner.sv ----
// Model of the controller side feeding role and attach state
`timescale 1ns/1ps
module usb_role_partner
    import usb_alloc_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       host_i,
    input  wire logic [1:0] speed_i,
    output role_in_t        role_o
);
    // Speed is only seen in host role, and a session always runs with it
    always_ff @(posedge ref_clk_i) begin
        role_o <= {host_i, host_i, host_i & speed_i[1], host_i & speed_i[0]};
    end
endmodule // usb_role_partner

// ---- test/usb_fifo_alloc_and_role_status_tb_top.sv ----
// Self-checking bench for the role status and FIFO allocation block
`timescale 1ns/1ps
module usb_fifo_alloc_and_role_status_tb_top
    import usb_alloc_pkg::*;
;
    logic        ref_clk_i = 1'b0, reset_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, host = 1'b0, irq_o;
    logic [7:0]  addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000, rdata_o;
    logic [1:0]  speed = 2'h0, sel_ep_o;
    role_in_t    role_i;
    fifo_alloc_t tx_alloc_o, rx_alloc_o;
    int          n_fail = 0, checks_done = 0;
    usb_role_partner u_far (.ref_clk_i(ref_clk_i), .host_i(host), .speed_i(speed), .role_o(role_i));
    usb_fifo_alloc_and_role_status u_dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .role_i(role_i),
        .sel_ep_o(sel_ep_o), .tx_alloc_o(tx_alloc_o), .rx_alloc_o(rx_alloc_o), .irq_o(irq_o));
    initial begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
        #1;
    endtask
    // The release flag lets the first read land on the first edge out of reset
    task automatic rd(input logic [7:0] a, input logic [15:0] exp, input bit rel = 1'b0);
        @(posedge ref_clk_i);
        if (rel) reset_i <= 1'b0;
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask
    task automatic t_role();
        for (int h = 0; h < 2; h++) begin
            for (int s = 0; s < 3; s++) begin
                host <= h[0];
                speed <= s[1:0];
                wr(8'h60, 16'hffff);
                rd(8'h60, {9'h0, h[0] && s == 2, h[0] && s == 1, 2'h0, h[0], 2'h0});
            end
        end
    endtask
    task automatic t_size();
        wr(8'h0e, 16'h0002);
        chk(sel_ep_o, 16'h0002);
        for (int c = 0; c < 9; c++) begin
            wr(8'h62, {11'h7ff, c[0], c[3:0]});
            chk(tx_alloc_o.size_bytes, (c > 8) ? 16'h0 : (16'h8 << c) << c[0]);
            chk(tx_alloc_o.double_buffer_enable, c[0]);
            rd(8'h62, {11'h0, c[0], c[3:0]});
        end
    endtask
    task automatic t_ep();
        for (int e = 0; e < 4; e++) begin
            wr(8'h0e, 16'(e));
            wr(8'h64, 16'hfe00 | 16'(e * 65));
            wr(8'h66, 16'h01ff - 16'(e));
            chk(rx_alloc_o.start_byte, (16'h01ff - 16'(e)) << 3);
        end
        for (int e = 3; e >= 0; e--) begin
            wr(8'h0e, 16'(e));
            rd(8'h64, 16'(e * 65));
            chk(tx_alloc_o.start_byte, 16'(e * 65) << 3);
        end
    endtask
    task automatic t_irq();
        speed <= 2'h0;
        wr(8'h41, 16'h0000);
        wr(8'h40, 16'h0003);
        chk(irq_o, 1'b0);
        wr(8'h41, 16'h0001);
        host <= ~host;
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk(irq_o, 1'b1);
        rd(8'h40, 16'h0001);
        wr(8'h40, 16'h0001);
        @(posedge ref_clk_i);
        #1;
        chk(irq_o, 1'b0);
        rd(8'h10, 16'h0000);
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rd(8'h60, 16'h0080, 1'b1);
        t_role();
        t_size();
        t_ep();
        t_irq();
        report_and_stop();
    end
    initial begin
        #200us;
        n_fail++;
        report_and_stop();
    end
endmodule // usb_fifo_alloc_and_role_status_tb_top
